/* hdl/dcs_pkg.sv */
/*
 * constants, types and helpers shared by the drive serial command slave.
 * assumes one 100 MHz system clock and a default 1-8-2 rtu serial line.
 */
// Functional notes
// (RULE1) line characters: one start, eight data, no parity, two stop; 9600 bit/s.
// (RULE2) only frames whose first byte equals the station address are acted on; default 0x02.
// (RULE3) write function 0x06 to frequency_reference replaces frequency when frequency source is serial.
// (RULE4) frequency value is unsigned 16 bits, hundredths of hertz, high byte first.
// (RULE5) control word 0x1001 to run_control_word starts forward run when command source is serial.
// (RULE6) control word 0x1004 to the run-control register gives a decelerating stop.
// (RULE7) terminal source: forward alone runs forward, reverse alone reverse, both/none stop.
// (RULE8) default input functions: first input code 2 forward, second input code 3 reverse.
// (RULE9) auto-tuning may start only under keypad command source.
// (RULE10) tuning mode 1 runs standstill tuning, then updates stator, rotor, leakage values.
// (RULE11) tuning mode 2 with run key starts a tuning that turns the motor.
// (RULE12) rotating tuning done rewrites rated speed and all model values through saturation 5.
// (RULE13) tuning mode 3 measures and updates only the stator resistance.
// (RULE14) stop key during rotating tuning aborts it at once.
// (RULE15) write frame: address, function, register hi/lo, value hi/lo, 16-bit crc.
// (RULE16) an accepted write is echoed byte for byte, checksum included.
package dcs_pkg;
    localparam int          CLK_HZ            = 100_000_000;
    localparam int          LINE_BPS          = 9600;
    localparam int          DATA_BITS         = 8;
    localparam int          STOP_BITS         = 2;
    localparam int          FRAME_LEN         = 8;
    localparam int          GAP_HALF_BITS     = 77;       // 3.5 characters of 11 bits
    localparam logic [7:0]  STATION_DEFAULT   = 8'h02;
    localparam logic [7:0]  FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [15:0] REG_RUN_CONTROL   = 16'h3200;
    localparam logic [15:0] REG_FREQ_REF      = 16'h3201;
    localparam logic [15:0] CTRL_FWD_START    = 16'h1001;
    localparam logic [15:0] CTRL_DEC_STOP     = 16'h1004;
    localparam logic [1:0]  SRC_KEYPAD        = 2'h0;
    localparam logic [1:0]  SRC_TERMINAL      = 2'h1;
    localparam logic [1:0]  SRC_SERIAL        = 2'h2;
    localparam logic [7:0]  IN_FUNC_FORWARD   = 8'h02;
    localparam logic [7:0]  IN_FUNC_REVERSE   = 8'h03;
    localparam logic [1:0]  TUNE_NONE         = 2'h0;
    localparam logic [1:0]  TUNE_STATIC       = 2'h1;
    localparam logic [1:0]  TUNE_ROTATING     = 2'h2;
    localparam logic [1:0]  TUNE_STATOR       = 2'h3;
    localparam logic [15:0] CRC_INIT          = 16'hffff;
    localparam logic [15:0] CRC_POLY          = 16'ha001;
    localparam int          IDX_ADDR = 0, IDX_FUNC = 1, IDX_REG_HI = 2, IDX_REG_LO = 3;
    localparam int          IDX_VAL_HI = 4, IDX_VAL_LO = 5, IDX_CRC_LO = 6, IDX_CRC_HI = 7;

    typedef struct packed {
        logic fwd;
        logic rev;
    } dcs_run_cmd_t;

    typedef struct packed {
        logic rated_speed;
        logic stator_res;
        logic rotor_res;
        logic leakage;
        logic model_rest;   // mutual, no-load current, saturation 1..5
    } dcs_tune_update_t;

    // one byte through the reflected modbus crc
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

/* hdl/dcs_drive_slave.sv */
/*
 * serial command slave and run-control selector for a motor drive.
 * assumes a serial master on i_rx/o_tx, raw keys and terminals from pins,
 * settings held stable by the surrounding parameter store.
 */
`timescale 1ns/10ps
module dcs_drive_slave #(
    parameter int BIT_CYC = dcs_pkg::CLK_HZ / dcs_pkg::LINE_BPS,   // cycles per line bit
    parameter int GAP_CYC = BIT_CYC * dcs_pkg::GAP_HALF_BITS / 2    // end-of-frame silence
) (
    input  wire logic                      i_sys_clk,          // system clock
    input  wire logic                      i_reset_n,          // sync reset, low
    input  wire logic                      i_rx,               // serial line in
    output logic                           o_tx,               // serial line out
    input  wire logic [7:0]                i_station_addr,     // station address setting
    input  wire logic [1:0]                i_freq_src_sel,     // frequency source select
    input  wire logic [1:0]                i_cmd_src_sel,      // command source select
    input  wire logic [7:0]                i_first_input_func, // first input function
    input  wire logic [7:0]                i_second_input_func,// second input function
    input  wire logic                      i_forward_input,    // first terminal, high active
    input  wire logic                      i_reverse_input,    // second terminal, high active
    input  wire logic                      i_run_key,          // keypad run key
    input  wire logic                      i_stop_key,         // keypad stop key
    input  wire logic [1:0]                i_tuning_mode,      // tuning mode select
    input  wire logic                      i_tune_done,        // tuning finished, one pulse
    output dcs_pkg::dcs_run_cmd_t          o_run_cmd,          // run direction command
    output logic [15:0]                    o_freq_ref,         // frequency, 0.01 Hz
    output logic [15:0]                    o_run_control_word, // last control word
    output logic                           o_running,          // running indicator output
    output logic [1:0]                     o_tuning,           // active tuning mode, 0 none
    output dcs_pkg::dcs_tune_update_t      o_tune_update       // value refresh strobes
);
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_DATA = 2'b10, ST_STOP = 2'b11} dcs_ser_st_t;

    // two-flop synchronisers; only the second stage is read
    logic [1:0] rx_s_q, fwd_s_q, rev_s_q, run_s_q, stop_s_q;
    logic       run_key_d1_q, stop_key_d1_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rx_s_q        <= 2'h3;
            fwd_s_q       <= 2'h0;
            rev_s_q       <= 2'h0;
            run_s_q       <= 2'h0;
            stop_s_q      <= 2'h0;
            run_key_d1_q  <= 1'b0;
            stop_key_d1_q <= 1'b0;
        end else begin
            rx_s_q        <= {rx_s_q[0], i_rx};
            fwd_s_q       <= {fwd_s_q[0], i_forward_input};
            rev_s_q       <= {rev_s_q[0], i_reverse_input};
            run_s_q       <= {run_s_q[0], i_run_key};
            stop_s_q      <= {stop_s_q[0], i_stop_key};
            run_key_d1_q  <= run_s_q[1];
            stop_key_d1_q <= stop_s_q[1];
        end
    end
    logic run_press, stop_press, rx_line;
    assign run_press  = run_s_q[1] & ~run_key_d1_q;
    assign stop_press = stop_s_q[1] & ~stop_key_d1_q;
    assign rx_line    = rx_s_q[1];

    // receiver: start found mid-bit, eight data bits lsb first, stop checked
    dcs_ser_st_t rx_st_q;
    logic [31:0] rx_cnt_q, gap_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [7:0]  rx_sh_q;
    logic        rx_byte_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rx_st_q   <= ST_IDLE;
            rx_cnt_q  <= 32'h0;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 8'h00;
            rx_byte_q <= 1'b0;
        end else begin
            rx_byte_q <= 1'b0;
            unique case (rx_st_q)
                ST_IDLE: begin
                    rx_cnt_q <= 32'h0;
                    if (!rx_line) begin
                        rx_st_q <= ST_START;
                    end
                end
                ST_START: begin
                    rx_cnt_q <= rx_cnt_q + 32'h1;
                    if (rx_cnt_q == 32'(BIT_CYC / 2)) begin
                        rx_cnt_q <= 32'h0;
                        rx_bit_q <= 4'h0;
                        rx_st_q  <= rx_line ? ST_IDLE : ST_DATA;   // glitch rejected
                    end
                end
                ST_DATA: begin
                    rx_cnt_q <= rx_cnt_q + 32'h1;
                    if (rx_cnt_q == 32'(BIT_CYC - 1)) begin
                        rx_cnt_q <= 32'h0;
                        rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'(dcs_pkg::DATA_BITS - 1)) begin
                            rx_st_q <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    rx_cnt_q <= rx_cnt_q + 32'h1;
                    if (rx_cnt_q == 32'(BIT_CYC - 1)) begin
                        rx_st_q   <= ST_IDLE;
                        rx_byte_q <= rx_line;   // framing error drops the byte [RULE1]
                    end
                end
            endcase
        end
    end

    // silence timer: a gap of 3.5 characters closes the frame
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            gap_cnt_q <= 32'h0;
        end else if (rx_st_q != ST_IDLE || !rx_line) begin
            gap_cnt_q <= 32'h0;
        end else if (gap_cnt_q != 32'(GAP_CYC)) begin
            gap_cnt_q <= gap_cnt_q + 32'h1;
        end
    end

    // frame assembly; bytes past the eighth are ignored until silence [RULE15]
    dcs_ser_st_t tx_st_q;
    logic [7:0]  frame_q [dcs_pkg::FRAME_LEN];
    logic [3:0]  idx_q;
    logic [15:0] crc_q;
    logic        frame_done_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            idx_q        <= 4'h0;
            crc_q        <= dcs_pkg::CRC_INIT;
            frame_done_q <= 1'b0;
            for (int i = 0; i < dcs_pkg::FRAME_LEN; i++) begin
                frame_q[i] <= 8'h00;
            end
        end else begin
            frame_done_q <= 1'b0;
            if (gap_cnt_q == 32'(GAP_CYC)) begin
                idx_q <= 4'h0;
                crc_q <= dcs_pkg::CRC_INIT;
            end else if (rx_byte_q && tx_st_q == ST_IDLE && idx_q < 4'(dcs_pkg::FRAME_LEN)) begin
                frame_q[idx_q[2:0]] <= rx_sh_q;
                idx_q               <= idx_q + 4'h1;
                if (idx_q < 4'(dcs_pkg::IDX_CRC_LO)) begin
                    crc_q <= dcs_pkg::crc_byte(crc_q, rx_sh_q);
                end
                frame_done_q <= (idx_q == 4'(dcs_pkg::FRAME_LEN - 1));
            end
        end
    end

    // decode of a complete frame; unknown registers get no answer
    logic [15:0] reg_addr, reg_val;
    logic        accept;
    assign reg_addr = {frame_q[dcs_pkg::IDX_REG_HI], frame_q[dcs_pkg::IDX_REG_LO]};
    assign reg_val  = {frame_q[dcs_pkg::IDX_VAL_HI], frame_q[dcs_pkg::IDX_VAL_LO]};   // high byte first [RULE4]
    assign accept   = frame_done_q
                    && frame_q[dcs_pkg::IDX_ADDR] == i_station_addr                    // [RULE2]
                    && frame_q[dcs_pkg::IDX_FUNC] == dcs_pkg::FUNC_WRITE_SINGLE
                    && crc_q == {frame_q[dcs_pkg::IDX_CRC_HI], frame_q[dcs_pkg::IDX_CRC_LO]}
                    && (reg_addr == dcs_pkg::REG_RUN_CONTROL || reg_addr == dcs_pkg::REG_FREQ_REF);

    // register writes; frequency only taken while the link owns it
    logic ser_run_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_freq_ref         <= 16'h0000;
            o_run_control_word <= 16'h0000;
            ser_run_q          <= 1'b0;
        end else if (accept) begin
            if (reg_addr == dcs_pkg::REG_FREQ_REF && i_freq_src_sel == dcs_pkg::SRC_SERIAL) begin
                o_freq_ref <= reg_val;   // [RULE3] [RULE4]
            end
            if (reg_addr == dcs_pkg::REG_RUN_CONTROL) begin
                o_run_control_word <= reg_val;
                if (reg_val == dcs_pkg::CTRL_FWD_START) begin
                    ser_run_q <= 1'b1;   // [RULE5]
                end else if (reg_val == dcs_pkg::CTRL_DEC_STOP) begin
                    ser_run_q <= 1'b0;   // ramp-down is the motor side's job [RULE6]
                end
            end
        end
    end

    // echo transmitter: replays the stored frame, crc bytes included
    logic [31:0] tx_cnt_q;
    logic [3:0]  tx_bit_q, tx_idx_q;
    logic [7:0]  tx_sh_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            tx_st_q  <= ST_IDLE;
            tx_cnt_q <= 32'h0;
            tx_bit_q <= 4'h0;
            tx_idx_q <= 4'h0;
            tx_sh_q  <= 8'h00;
            o_tx     <= 1'b1;
        end else begin
            unique case (tx_st_q)
                ST_IDLE: begin
                    if (accept) begin
                        tx_st_q  <= ST_START;   // [RULE16]
                        tx_idx_q <= 4'h0;
                        tx_cnt_q <= 32'h0;
                        tx_sh_q  <= frame_q[dcs_pkg::IDX_ADDR];
                        o_tx     <= 1'b0;
                    end
                end
                ST_START: begin
                    tx_cnt_q <= tx_cnt_q + 32'h1;
                    if (tx_cnt_q == 32'(BIT_CYC - 1)) begin
                        tx_cnt_q <= 32'h0;
                        tx_bit_q <= 4'h0;
                        tx_st_q  <= ST_DATA;
                        o_tx     <= tx_sh_q[0];
                    end
                end
                ST_DATA: begin
                    tx_cnt_q <= tx_cnt_q + 32'h1;
                    if (tx_cnt_q == 32'(BIT_CYC - 1)) begin
                        tx_cnt_q <= 32'h0;
                        tx_bit_q <= tx_bit_q + 4'h1;
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        o_tx     <= tx_sh_q[1];
                        if (tx_bit_q == 4'(dcs_pkg::DATA_BITS - 1)) begin
                            tx_st_q  <= ST_STOP;
                            tx_bit_q <= 4'h0;
                            o_tx     <= 1'b1;
                        end
                    end
                end
                ST_STOP: begin
                    tx_cnt_q <= tx_cnt_q + 32'h1;
                    if (tx_cnt_q == 32'(BIT_CYC * dcs_pkg::STOP_BITS - 1)) begin   // two stop bits [RULE1]
                        tx_cnt_q <= 32'h0;
                        if (tx_idx_q == 4'(dcs_pkg::FRAME_LEN - 1)) begin
                            tx_st_q <= ST_IDLE;
                        end else begin
                            tx_st_q  <= ST_START;
                            tx_idx_q <= tx_idx_q + 4'h1;
                            tx_sh_q  <= frame_q[3'(tx_idx_q + 4'h1)];
                            o_tx     <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // terminal whose function code selects the given direction
    function automatic logic term_dir(input logic [7:0] code, input logic [7:0] f1, input logic f1_on,
                                      input logic [7:0] f2, input logic f2_on);
        return (f1 == code && f1_on) || (f2 == code && f2_on);
    endfunction

    // auto-tuning sequencer; only reachable from keypad
    logic kp_run_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_tuning      <= dcs_pkg::TUNE_NONE;
            o_tune_update <= '0;
            kp_run_q      <= 1'b0;
        end else begin
            o_tune_update <= '0;
            if (i_cmd_src_sel != dcs_pkg::SRC_KEYPAD) begin
                kp_run_q <= 1'b0;
            end else if (o_tuning == dcs_pkg::TUNE_NONE) begin
                if (run_press && i_tuning_mode != dcs_pkg::TUNE_NONE) begin
                    o_tuning <= i_tuning_mode;   // [RULE9] [RULE10] [RULE11] [RULE13]
                end else if (run_press) begin
                    kp_run_q <= 1'b1;
                end else if (stop_press) begin
                    kp_run_q <= 1'b0;
                end
            end else if (stop_press && o_tuning == dcs_pkg::TUNE_ROTATING) begin
                o_tuning <= dcs_pkg::TUNE_NONE;   // abort, no values refreshed [RULE14]
            end else if (i_tune_done) begin
                o_tuning                 <= dcs_pkg::TUNE_NONE;
                o_tune_update.stator_res <= 1'b1;   // [RULE13]
                o_tune_update.rotor_res  <= (o_tuning != dcs_pkg::TUNE_STATOR);   // [RULE10]
                o_tune_update.leakage    <= (o_tuning != dcs_pkg::TUNE_STATOR);
                o_tune_update.rated_speed <= (o_tuning == dcs_pkg::TUNE_ROTATING);   // [RULE12]
                o_tune_update.model_rest <= (o_tuning == dcs_pkg::TUNE_ROTATING);
            end
        end
    end

    // run command selection; both terminals or none means stop
    logic term_f, term_r;
    assign term_f = term_dir(dcs_pkg::IN_FUNC_FORWARD, i_first_input_func, fwd_s_q[1],
                             i_second_input_func, rev_s_q[1]);   // [RULE8]
    assign term_r = term_dir(dcs_pkg::IN_FUNC_REVERSE, i_first_input_func, fwd_s_q[1],
                             i_second_input_func, rev_s_q[1]);
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_run_cmd <= '0;
            o_running <= 1'b0;
        end else begin
            unique case (i_cmd_src_sel)
                dcs_pkg::SRC_TERMINAL: o_run_cmd <= '{fwd: term_f & ~term_r, rev: term_r & ~term_f};   // [RULE7]
                dcs_pkg::SRC_SERIAL:   o_run_cmd <= '{fwd: ser_run_q, rev: 1'b0};
                default:               o_run_cmd <= '{fwd: kp_run_q, rev: 1'b0};
            endcase
            o_running <= o_run_cmd.fwd | o_run_cmd.rev | (o_tuning != dcs_pkg::TUNE_NONE);
        end
    end

    // checks on the decoded write, the echo line and the run/tuning outputs
    sequence s_run_write(logic [15:0] w);
        accept && reg_addr == dcs_pkg::REG_RUN_CONTROL && reg_val == w && i_cmd_src_sel == dcs_pkg::SRC_SERIAL;
    endsequence
    property p_addr_match;
        @(posedge i_sys_clk) disable iff (!i_reset_n) accept |-> frame_q[dcs_pkg::IDX_ADDR] == i_station_addr;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("write accepted for another station"); // [RULE2]
    property p_freq_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            accept && reg_addr == dcs_pkg::REG_FREQ_REF && i_freq_src_sel == dcs_pkg::SRC_SERIAL
            |=> o_freq_ref == $past(reg_val);
    endproperty
    a_freq_write: assert property (p_freq_write) else $error("frequency reference not updated"); // [RULE3]
    property p_fwd_start;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            s_run_write(dcs_pkg::CTRL_FWD_START) ##1 i_cmd_src_sel == dcs_pkg::SRC_SERIAL |=> o_run_cmd.fwd;
    endproperty
    a_fwd_start: assert property (p_fwd_start) else $error("forward start not issued"); // [RULE5]
    property p_dec_stop;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            s_run_write(dcs_pkg::CTRL_DEC_STOP) ##1 i_cmd_src_sel == dcs_pkg::SRC_SERIAL |=> !o_run_cmd.fwd;
    endproperty
    a_dec_stop: assert property (p_dec_stop) else $error("stop not issued"); // [RULE6]
    property p_terminal_both;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            i_cmd_src_sel == dcs_pkg::SRC_TERMINAL && term_f && term_r |=> !o_run_cmd.fwd && !o_run_cmd.rev;
    endproperty
    a_terminal_both: assert property (p_terminal_both) else $error("run with both terminals active"); // [RULE7]
    property p_tune_keypad;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            $rose(o_tuning != dcs_pkg::TUNE_NONE) |-> $past(i_cmd_src_sel) == dcs_pkg::SRC_KEYPAD;
    endproperty
    a_tune_keypad: assert property (p_tune_keypad) else $error("tuning started off keypad"); // [RULE9]
    property p_stator_only;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            o_tuning == dcs_pkg::TUNE_STATOR && i_tune_done && !stop_press
            |=> o_tune_update == dcs_pkg::dcs_tune_update_t'(5'b01000);
    endproperty
    a_stator_only: assert property (p_stator_only) else $error("stator-only tuning refreshed more"); // [RULE13]
    property p_rot_abort;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            o_tuning == dcs_pkg::TUNE_ROTATING && stop_press && i_cmd_src_sel == dcs_pkg::SRC_KEYPAD
            |=> o_tuning == dcs_pkg::TUNE_NONE && o_tune_update == '0;
    endproperty
    a_rot_abort: assert property (p_rot_abort) else $error("rotating tuning not aborted"); // [RULE14]
    property p_echo_start;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            accept |=> !o_tx && tx_st_q == ST_START && tx_sh_q == $past(frame_q[dcs_pkg::IDX_ADDR]);
    endproperty
    a_echo_start: assert property (p_echo_start) else $error("echo did not start"); // [RULE16]
    property p_stop_high;
        @(posedge i_sys_clk) disable iff (!i_reset_n) tx_st_q == ST_STOP |-> o_tx;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // [RULE1]
endmodule

/* bench/dcs_mst.sv */
/* rtu master model: sends write frames, gathers the echo.
   assumes an idle-high line into the slave. */
`timescale 1ns/10ps
module dcs_mst #(parameter int BIT_CYC = 16) (
    input  wire logic i_sys_clk, // clock
    input  wire logic i_tx,      // slave answer
    output logic      o_rx       // request, idle high
);
    logic [7:0] echo_q[$], sent_q[$];
    initial o_rx = 1'b1;
    // start, data lsb first, two stop
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge i_sys_clk);
            o_rx <= f[i];
            repeat (BIT_CYC - 1) @(posedge i_sys_clk);
        end
    endtask
    // addr, func, reg, value, crc low first
    task automatic send_frame(input logic [7:0] a, input logic [15:0] r, input logic [15:0] v);
        logic [15:0] c;
        c = 16'hffff;
        sent_q = '{a, 8'h06, r[15:8], r[7:0], v[15:8], v[7:0]};
        echo_q.delete();
        foreach (sent_q[i]) begin
            c = c ^ {8'h00, sent_q[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        sent_q.push_back(c[7:0]);
        sent_q.push_back(c[15:8]);
        foreach (sent_q[i]) send_byte(sent_q[i]);
    endtask
    // mid-bit sampler; a bad echo shows up as a byte mismatch
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge i_tx);
            repeat (BIT_CYC * 3 / 2) @(posedge i_sys_clk);
            for (int i = 0; i < 8; i++) begin
                b[i] = i_tx;
                repeat (BIT_CYC) @(posedge i_sys_clk);
            end
            echo_q.push_back(b);
        end
    end
endmodule

/* bench/dcs_drive_slave_tb.sv */
/* bench: serial writes, terminal run and keypad tuning of the drive slave.
   assumes the master model on the line and a 16-cycle bit time. */
`timescale 1ns/10ps
module dcs_drive_slave_tb;
    logic i_sys_clk = 0, i_reset_n = 0, rx, tx, fwd = 0, rev = 0, run_k = 0, stop_k = 0, done = 0, running;
    logic [1:0]                fsrc = 2'h2, csrc = 2'h2, tmode = 2'h0, tuning;
    logic [15:0]               freq, cword;
    logic [7:0]                sta = 8'h02;   // station address setting, driven so it is not a tie-off
    dcs_pkg::dcs_run_cmd_t     run_cmd;
    dcs_pkg::dcs_tune_update_t upd, seen;
    logic [4:0]                exp_upd [1:3] = '{5'h0e, 5'h1f, 5'h08};
    int                        fails = 0, n_tests = 0;
    dcs_drive_slave #(.BIT_CYC(16), .GAP_CYC(600)) dcs_drive_slave_inst (.i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n), .i_rx(rx), .o_tx(tx), .i_station_addr(sta), .i_freq_src_sel(fsrc),
        .i_cmd_src_sel(csrc), .i_first_input_func(8'h02), .i_second_input_func(8'h03), .i_forward_input(fwd),
        .i_reverse_input(rev), .i_run_key(run_k), .i_stop_key(stop_k), .i_tuning_mode(tmode), .i_tune_done(done),
        .o_run_cmd(run_cmd), .o_freq_ref(freq), .o_run_control_word(cword), .o_running(running),
        .o_tuning(tuning), .o_tune_update(upd));
    dcs_mst #(.BIT_CYC(16)) dcs_mst_inst (.i_sys_clk(i_sys_clk), .i_tx(tx), .o_rx(rx));
    initial forever #5 i_sys_clk = ~i_sys_clk;
    // strobes last one cycle, so keep the last one seen
    always @(posedge i_sys_clk) if (upd != 5'h00) seen <= upd;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            fails++;
    endtask
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one write; wait bounded for the echo, then hold the line quiet past the gap
    task automatic frame(input logic [7:0] a, input logic [15:0] r, input logic [15:0] v, input int n_echo);
        int n;
        dcs_mst_inst.send_frame(a, r, v);
        for (n = 0; n < 2000 && dcs_mst_inst.echo_q.size() < n_echo; n++) @(posedge i_sys_clk);
        repeat (700) @(posedge i_sys_clk);
        chk(16'(dcs_mst_inst.echo_q.size()), 16'(n_echo));
        for (int i = 0; i < n_echo; i++) chk(dcs_mst_inst.echo_q[i], dcs_mst_inst.sent_q[i]);
        if (n == 2000)
            close_out();
    endtask
    // 0 run key, 1 stop key, 2 tuning finished
    task automatic pulse(input int w);
        @(posedge i_sys_clk);
        {done, stop_k, run_k} <= 3'(1 << w);
        repeat ((w == 2) ? 1 : 4) @(posedge i_sys_clk);
        {done, stop_k, run_k} <= 3'h0;
        repeat (6) @(posedge i_sys_clk);
    endtask
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (5) @(posedge i_sys_clk);
        frame(8'h02, 16'h3201, 16'h1194, 8);
        chk(freq, 16'h1194);
        frame(8'h03, 16'h3201, 16'h0001, 0);
        fsrc <= 2'h0;
        frame(8'h02, 16'h3201, 16'h0bb8, 8);
        chk(freq, 16'h1194);
        frame(8'h02, 16'h3200, 16'h1001, 8);
        chk({13'h0, running, run_cmd}, 16'h0006);
        frame(8'h02, 16'h3200, 16'h1004, 8);
        chk({cword[15:2], run_cmd}, 16'h1004);
        csrc <= 2'h1;
        for (int c = 0; c < 4; c++) begin
            {fwd, rev} <= 2'(c);
            repeat (5) @(posedge i_sys_clk);
            chk({13'h0, running, run_cmd}, (c % 3 != 0) ? 16'(c + 4) : 16'h0000);
        end
        tmode <= 2'h1;
        pulse(0);
        chk(16'(tuning), 16'h0000);
        csrc <= 2'h0;
        for (int m = 1; m < 4; m++) begin
            tmode <= 2'(m);
            pulse(0);
            chk(16'(tuning), 16'(m));
            pulse(2);
            chk({9'h0, seen, tuning}, {9'h0, exp_upd[m], 2'h0});
        end
        tmode <= 2'h2;
        pulse(0);
        pulse(1);
        pulse(2);
        chk({9'h0, seen, tuning}, 16'h0020);
        close_out();
    end
endmodule
